// ===== src/alsp_top.sv
// ambient light parameter register, measurement sequencer and result regs
// assumes a serial-interface slave drives the register port one access
// per cycle, and the analogue front end answers conversion requests
`timescale 1ns/1ns
module alsp_top #(
  parameter int P_RATE_BASE_CYC = alsp_pkg::RATE_BASE_CYC
) (
  input  wire logic                          i_clk,
  input  wire logic                          i_nrst,
  input  wire logic [alsp_pkg::ADDR_W-1:0]   i_reg_addr,
  input  wire logic                          i_reg_wr,
  input  wire logic                          i_reg_rd,
  input  wire logic [alsp_pkg::DATA_W-1:0]   i_reg_wdata,
  output logic      [alsp_pkg::DATA_W-1:0]   o_reg_rdata,
  input  wire logic                          i_self_timed_en,
  input  wire logic                          i_od_start,
  input  wire logic                          i_conv_done,
  input  wire logic [alsp_pkg::RES_W-1:0]    i_conv_data,
  input  wire logic                          i_prox_valid,
  input  wire logic [alsp_pkg::RES_W-1:0]    i_prox_data,
  output logic                               o_conv_req,
  output logic                               o_conv_offset,
  output logic                               o_als_ready,
  output logic                               o_busy
);
  ////////////////////////////////////////////////////////////////////////
  // reset release
  logic [alsp_pkg::RST_STAGES-1:0] rst_sync_ff;
  logic                            rst_n;

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rst_sync_ff <= '0;
    end else begin
      rst_sync_ff <= {rst_sync_ff[alsp_pkg::RST_STAGES-2:0], 1'b1};
    end
  end
  assign rst_n = rst_sync_ff[alsp_pkg::RST_STAGES-1];

  ////////////////////////////////////////////////////////////////////////
  // register file
  logic [alsp_pkg::DATA_W-1:0] param_ff;
  logic [alsp_pkg::DATA_W-1:0] act_param_ff;
  logic [alsp_pkg::RES_W-1:0]  als_result_ff;
  logic [alsp_pkg::RES_W-1:0]  prox_result_ff;
  logic [alsp_pkg::DATA_W-1:0] rdata_ff;

  wire sel_param   = (i_reg_addr == alsp_pkg::ADDR_PARAM);
  wire sel_als_hi  = (i_reg_addr == alsp_pkg::ADDR_ALS_HI);
  wire sel_als_lo  = (i_reg_addr == alsp_pkg::ADDR_ALS_LO);
  wire sel_prox_hi = (i_reg_addr == alsp_pkg::ADDR_PROX_HI);
  wire sel_prox_lo = (i_reg_addr == alsp_pkg::ADDR_PROX_LO);
  wire param_wr    = i_reg_wr & sel_param;

  // unmapped addresses read as zero
  wire [alsp_pkg::DATA_W-1:0] nxt_rdata =
    sel_param   ? param_ff :
    sel_als_hi  ? als_result_ff[15:8] :
    sel_als_lo  ? als_result_ff[7:0] :
    sel_prox_hi ? prox_result_ff[15:8] :
    sel_prox_lo ? prox_result_ff[7:0] :
    8'h00;

  // settings are frozen while self-timed runs; re-enabling picks up
  // whatever was written meanwhile, since the copy tracks when off
  wire [alsp_pkg::DATA_W-1:0] nxt_act_param =
    i_self_timed_en ? act_param_ff : param_ff;

  wire                            act_cont = act_param_ff[alsp_pkg::CONT_BIT];
  wire                            act_offs = act_param_ff[alsp_pkg::OFFS_BIT];
  wire [alsp_pkg::RATE_W-1:0]     act_rate =
    act_param_ff[alsp_pkg::RATE_LSB +: alsp_pkg::RATE_W];
  wire [alsp_pkg::AVG_W-1:0]      act_avg  =
    act_param_ff[alsp_pkg::AVG_LSB +: alsp_pkg::AVG_W];

  alsp_avg_if avg_bus ();

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      param_ff       <= alsp_pkg::PARAM_RESET;
      act_param_ff   <= alsp_pkg::PARAM_RESET;
      als_result_ff  <= '0;
      prox_result_ff <= '0;
      rdata_ff       <= '0;
    end else begin
      if (param_wr) begin
        param_ff <= i_reg_wdata;
      end
      act_param_ff <= nxt_act_param;
      if (i_reg_rd) begin
        rdata_ff <= nxt_rdata;
      end
      // result registers change only from measurements
      if (avg_bus.done) begin
        als_result_ff <= avg_bus.result;
      end
      if (i_prox_valid) begin
        prox_result_ff <= i_prox_data;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // self-timed rate timer: base period halves with each rate code
  logic [alsp_pkg::TMR_W-1:0] tmr_ff;

  wire [alsp_pkg::TMR_W-1:0] base_cyc   = alsp_pkg::TMR_W'(P_RATE_BASE_CYC);
  wire [alsp_pkg::TMR_W-1:0] tmr_reload = (base_cyc >> act_rate) - 27'h1;
  wire                       tmr_hit    = i_self_timed_en &&
                                          (tmr_ff == '0);

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      tmr_ff <= '0;
    end else if (!i_self_timed_en || tmr_hit) begin
      tmr_ff <= tmr_reload;
    end else begin
      tmr_ff <= tmr_ff - 27'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // measurement sequencer
  alsp_pkg::alsp_state_t       state_ff;
  alsp_pkg::alsp_state_t       nxt_state;
  logic [alsp_pkg::RES_W-1:0]  offset_ff;

  // continuous mode restarts on its own only outside self-timed mode
  wire cont_go = act_cont & ~i_self_timed_en;
  wire go      = tmr_hit | i_od_start | cont_go;

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      alsp_pkg::ALSP_IDLE: begin
        if (go) begin
          nxt_state = act_offs ? alsp_pkg::ALSP_OFFSET
                               : alsp_pkg::ALSP_CONV;
        end
      end
      alsp_pkg::ALSP_OFFSET: begin
        if (i_conv_done) begin
          nxt_state = alsp_pkg::ALSP_CONV;
        end
      end
      alsp_pkg::ALSP_CONV: begin
        if (avg_bus.done) begin
          nxt_state = alsp_pkg::ALSP_DONE;
        end
      end
      alsp_pkg::ALSP_DONE: begin
        nxt_state = alsp_pkg::ALSP_IDLE;
      end
      default: begin
        nxt_state = alsp_pkg::ALSP_IDLE;
      end
    endcase
  end

  wire enter_conv = (nxt_state == alsp_pkg::ALSP_CONV) &&
                    (state_ff != alsp_pkg::ALSP_CONV);

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff  <= alsp_pkg::ALSP_IDLE;
      offset_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      if (state_ff == alsp_pkg::ALSP_IDLE && go) begin
        offset_ff <= '0;
      end else if (state_ff == alsp_pkg::ALSP_OFFSET && i_conv_done) begin
        offset_ff <= i_conv_data;
      end
    end
  end

  assign avg_bus.start        = enter_conv;
  assign avg_bus.avg_sel      = act_avg;
  assign avg_bus.offset       = offset_ff;
  assign avg_bus.sample_valid = (state_ff == alsp_pkg::ALSP_CONV) &
                                i_conv_done;
  assign avg_bus.sample       = i_conv_data;

  alsp_avg u_avg (
    .i_clk   (i_clk),
    .i_rst_n (rst_n),
    .bus     (avg_bus)
  );

  assign o_reg_rdata   = rdata_ff;
  // drop the request once the last sample is in, otherwise the front end
  // starts a spare conversion while the average settles
  assign o_conv_req    = ((state_ff == alsp_pkg::ALSP_OFFSET) ||
                          (state_ff == alsp_pkg::ALSP_CONV)) &&
                         !avg_bus.done;
  assign o_conv_offset = (state_ff == alsp_pkg::ALSP_OFFSET);
  assign o_als_ready   = (state_ff == alsp_pkg::ALSP_DONE);
  assign o_busy        = (state_ff != alsp_pkg::ALSP_IDLE);

  ////////////////////////////////////////////////////////////////////////
  // checks
  AST_PARAM_RESET: assert property (@(posedge i_clk)
    $rose(rst_n) |-> param_ff == alsp_pkg::PARAM_RESET)
    else $error("parameter register reset value wrong");
  AST_CONT_RESET_OFF: assert property (@(posedge i_clk)
    $rose(rst_n) |-> !param_ff[alsp_pkg::CONT_BIT] && !cont_go)
    else $error("continuous mode on after reset");
  AST_PARAM_WRITE: assert property (
    @(posedge i_clk) disable iff (!rst_n)
    param_wr |=> param_ff == $past(i_reg_wdata))
    else $error("parameter write not stored");
  AST_FROZEN_PARAMS: assert property (
    @(posedge i_clk) disable iff (!rst_n)
    i_self_timed_en && $past(i_self_timed_en) |-> $stable(act_param_ff))
    else $error("settings changed during self-timed run");
  AST_ALS_READ_HI: assert property (
    @(posedge i_clk) disable iff (!rst_n)
    i_reg_rd && sel_als_hi |=> o_reg_rdata == $past(als_result_ff[15:8]))
    else $error("ambient high byte read wrong");
  AST_ALS_RO: assert property (
    @(posedge i_clk) disable iff (!rst_n)
    i_reg_wr && (sel_als_hi || sel_als_lo) && !avg_bus.done
    |=> $stable(als_result_ff))
    else $error("write changed ambient result");
  AST_PROX_READ_LO: assert property (
    @(posedge i_clk) disable iff (!rst_n)
    i_reg_rd && sel_prox_lo |=> o_reg_rdata == $past(prox_result_ff[7:0]))
    else $error("proximity low byte read wrong");
  AST_PROX_RO: assert property (
    @(posedge i_clk) disable iff (!rst_n)
    i_reg_wr && (sel_prox_hi || sel_prox_lo) && !i_prox_valid
    |=> $stable(prox_result_ff))
    else $error("write changed proximity result");
  AST_OFFSET_FIRST: assert property (
    @(posedge i_clk) disable iff (!rst_n)
    state_ff == alsp_pkg::ALSP_IDLE && go && act_offs
    |=> o_conv_offset)
    else $error("offset not measured before ambient run");
  AST_RATE_RELOAD: assert property (
    @(posedge i_clk) disable iff (!rst_n)
    tmr_hit |=> tmr_ff == $past(tmr_reload))
    else $error("rate timer reload wrong");

  COV_OFFSET_RUN: cover property (@(posedge i_clk) disable iff (!rst_n)
    o_conv_offset ##[1:300] o_als_ready);
  COV_SELF_TIMED: cover property (@(posedge i_clk) disable iff (!rst_n)
    tmr_hit ##1 o_busy);
  COV_CONT_BACK: cover property (@(posedge i_clk) disable iff (!rst_n)
    cont_go && o_als_ready ##1 (state_ff == alsp_pkg::ALSP_IDLE) ##1 o_busy);
endmodule

// ===== src/alsp_pkg.sv
// constants, types and helpers for the ambient light parameter block
// assumes one 125 MHz clock and an internal register port behind the
// serial interface, which sits outside this block
// Functional notes
// - continuous conversion bit 1 enables, 0 disables; reset value disabled.
// - with offset compensation, measure offset first and subtract it.
// - each measurement averages two to the power of averaging field.
// - averaging field resets to binary 101, thirty-two conversions.
// - self-timed run keeps old settings until its mode is cycled.
// - ambient result high byte at 85h, low byte at 86h.
// - ambient result bytes read only; writes leave them unchanged.
// - proximity result high byte at 87h, low byte at 88h.
// - proximity result bytes read only; writes have no effect.
// - parameter register at 84h: cont 7, rate 6:4, offset 3, avg 2:0.
package alsp_pkg;
  localparam int          ADDR_W       = 8;
  localparam int          DATA_W       = 8;
  localparam int          RES_W        = 16;
  localparam int          AVG_W        = 3;
  localparam int          RATE_W       = 3;
  localparam int          CNT_W        = 8;
  localparam int          ACC_W        = RES_W + 7;
  localparam int          TMR_W        = 27;
  localparam logic [7:0]  ADDR_PARAM   = 8'h84;
  localparam logic [7:0]  ADDR_ALS_HI  = 8'h85;
  localparam logic [7:0]  ADDR_ALS_LO  = 8'h86;
  localparam logic [7:0]  ADDR_PROX_HI = 8'h87;
  localparam logic [7:0]  ADDR_PROX_LO = 8'h88;
  localparam logic [7:0]  PARAM_RESET  = 8'h05;
  localparam int          CONT_BIT     = 7;
  localparam int          RATE_LSB     = 4;
  localparam int          OFFS_BIT     = 3;
  localparam int          AVG_LSB      = 0;
  localparam int          RST_STAGES   = 2;
  localparam int          CLK_HZ       = 125_000_000;
  localparam int          BASE_PERIOD_S = 1;
  localparam int          RATE_BASE_CYC = BASE_PERIOD_S * CLK_HZ;

  typedef enum logic [1:0] {
    ALSP_IDLE   = 2'b00,
    ALSP_OFFSET = 2'b01,
    ALSP_CONV   = 2'b11,
    ALSP_DONE   = 2'b10
  } alsp_state_t;

  // number of single conversions for an averaging code
  function automatic logic [CNT_W-1:0] conv_count(
    input logic [AVG_W-1:0] avg
  );
    conv_count = CNT_W'(1) << avg;
  endfunction
endpackage

// ===== src/alsp_avg_if.sv
// carrier between the sequencer and the averaging unit
// assumes both ends share the block clock
`timescale 1ns/1ns
interface alsp_avg_if;
  logic                                 start;
  logic [alsp_pkg::AVG_W-1:0]           avg_sel;
  logic [alsp_pkg::RES_W-1:0]           offset;
  logic                                 sample_valid;
  logic [alsp_pkg::RES_W-1:0]           sample;
  logic                                 done;
  logic [alsp_pkg::RES_W-1:0]           result;

  modport seq (output start, avg_sel, offset, sample_valid, sample,
               input done, result);
  modport avg (input start, avg_sel, offset, sample_valid, sample,
               output done, result);
endinterface

// ===== src/alsp_avg.sv
// averaging unit: sums 2^n conversions, divides, removes the offset
// assumes start is never raised while a run is busy
`timescale 1ns/1ns
module alsp_avg (
  input  wire logic   i_clk,
  input  wire logic   i_rst_n,
  alsp_avg_if.avg     bus
);
  logic                               busy_ff;
  logic [alsp_pkg::CNT_W-1:0]         cnt_ff;
  logic [alsp_pkg::ACC_W-1:0]         acc_ff;
  logic                               done_ff;
  logic [alsp_pkg::RES_W-1:0]         result_ff;
  logic [alsp_pkg::AVG_W-1:0]         avg_ff;

  wire                                take     = busy_ff & bus.sample_valid;
  wire [alsp_pkg::CNT_W-1:0]          nxt_cnt  = cnt_ff + 8'h01;
  wire [alsp_pkg::ACC_W-1:0]          nxt_acc  =
    acc_ff + alsp_pkg::ACC_W'(bus.sample);
  wire                                last     =
    take & (nxt_cnt == alsp_pkg::conv_count(avg_ff));
  wire [alsp_pkg::ACC_W-1:0]          mean_w   = nxt_acc >> avg_ff;
  // offset above the mean clips to zero rather than wrapping
  wire [alsp_pkg::RES_W-1:0]          nxt_result =
    (mean_w[alsp_pkg::RES_W-1:0] > bus.offset) ?
    mean_w[alsp_pkg::RES_W-1:0] - bus.offset : 16'h0000;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      busy_ff   <= 1'b0;
      cnt_ff    <= '0;
      acc_ff    <= '0;
      done_ff   <= 1'b0;
      result_ff <= '0;
      avg_ff    <= '0;
    end else begin
      done_ff <= last;
      if (bus.start) begin
        busy_ff <= 1'b1;
        cnt_ff  <= '0;
        acc_ff  <= '0;
        avg_ff  <= bus.avg_sel;
      end else if (take) begin
        cnt_ff  <= nxt_cnt;
        acc_ff  <= nxt_acc;
        if (last) begin
          busy_ff   <= 1'b0;
          result_ff <= nxt_result;
        end
      end
    end
  end

  assign bus.done   = done_ff;
  assign bus.result = result_ff;

  AST_AVG_LAST_DONE: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    last |=> done_ff && !busy_ff)
    else $error("average not finished after last conversion");
  AST_AVG_COUNT: assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    $rose(done_ff) |-> $past(nxt_cnt) == alsp_pkg::conv_count(avg_ff))
    else $error("wrong number of conversions averaged");
endmodule

// ===== sim/alsp_fe_model.sv
// behavioural analogue front end that answers conversion requests
// assumes the block holds its request level while conversions are wanted
`timescale 1ns/1ns
module alsp_fe_model (
  input  wire logic        i_clk,
  input  wire logic        i_req,
  input  wire logic        i_offs,
  input  wire logic        i_slow,
  input  wire logic        i_load,
  input  wire logic [15:0] i_offs_val,
  input  wire logic [15:0] i_base,
  input  wire logic [15:0] i_step,
  output logic             o_done,
  output logic      [15:0] o_data,
  output int               o_count
);
  logic [15:0] smp;
  logic [1:0]  gap;

  initial begin
    o_done = 1'b0;
    o_data = 16'h0000;
    o_count = 0;
    smp = 16'h0000;
    gap = 2'h0;
  end

  //////////////////////////////////////////////////////////////////////////
  always @(posedge i_clk) begin
    if (i_load) begin
      smp <= i_base;
    end
    if (o_done) begin
      o_done <= 1'b0;
      // data is only valid with the pulse, so scramble it afterwards
      o_data <= ~o_data;
      gap    <= i_slow ? 2'h3 : 2'h0;
    end else if (gap != 2'h0) begin
      gap <= gap - 2'h1;
    end else if (i_req) begin
      o_done  <= 1'b1;
      o_data  <= i_offs ? i_offs_val : smp;
      o_count <= o_count + 1;
      if (!i_offs) begin
        smp <= smp + i_step;
      end
    end
  end
endmodule

// ===== sim/tb_top.sv
// self-checking bench for the ambient light parameter block
// assumes the front end model answers every conversion request
`timescale 1ns/1ns
`define CHK(n, e, a) begin total_checks++; if ((a) !== (e)) begin \
  num_errors++; $display("[ERR] %s exp %h got %h", n, e, a); end end
module tb_top;
  logic        clk, nrst, wr, rd, st_en, od, pv, slow, load;
  logic [7:0]  addr, wdata, rdata;
  logic [15:0] pdata, offv, base, step, cdata, r16;
  logic        cdone, req, coff, rdy, busy;
  int          num_errors, total_checks, cnt, nrdy, c;

  alsp_top #(.P_RATE_BASE_CYC(64)) alsp_top_i (
    .i_clk(clk), .i_nrst(nrst), .i_reg_addr(addr), .i_reg_wr(wr),
    .i_reg_rd(rd), .i_reg_wdata(wdata), .o_reg_rdata(rdata),
    .i_self_timed_en(st_en), .i_od_start(od), .i_conv_done(cdone),
    .i_conv_data(cdata), .i_prox_valid(pv), .i_prox_data(pdata),
    .o_conv_req(req), .o_conv_offset(coff), .o_als_ready(rdy),
    .o_busy(busy));
  alsp_fe_model alsp_fe_model_i (
    .i_clk(clk), .i_req(req), .i_offs(coff), .i_slow(slow),
    .i_load(load), .i_offs_val(offv), .i_base(base), .i_step(step),
    .o_done(cdone), .o_data(cdata), .o_count(cnt));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(negedge clk) if (rdy === 1'b1) nrdy++;

  //////////////////////////////////////////////////////////////////////////
  task automatic wr8(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk) begin wr = 1'b1; addr = a; wdata = d; end
    @(negedge clk) wr = 1'b0;
  endtask
  task automatic rd8(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk) begin rd = 1'b1; addr = a; end
    @(negedge clk) rd = 1'b0;
    @(negedge clk) d = rdata;
  endtask
  task automatic rd16(input logic [7:0] a, output logic [15:0] d);
    rd8(a, d[15:8]);
    rd8(a + 8'h01, d[7:0]);
  endtask
  task automatic wait_rdy();
    int n;
    for (n = 0; n < 3000 && rdy !== 1'b1; n++) @(negedge clk);
    `CHK("ready", 1'b1, rdy)
    @(negedge clk);
  endtask
  task automatic wait_idle();
    repeat (20) @(negedge clk);
    for (int n = 0; n < 3000 && busy !== 1'b0; n++) @(negedge clk);
    `CHK("idle", 1'b0, busy)
  endtask
  task automatic go(input logic [15:0] b);
    @(negedge clk) begin base = b; load = 1'b1; od = 1'b1; end
    @(negedge clk) begin load = 1'b0; od = 1'b0; end
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rd8(8'h84, wdata);
    `CHK("param rst", 8'h05, wdata)
    for (int a = 8'h85; a <= 8'h88; a++) begin
      rd8(8'(a), wdata);
      `CHK("result rst", 8'h00, wdata)
    end
    rd8(8'h90, wdata);
    `CHK("unmapped", 8'h00, wdata)
    $display("test reset done");
  endtask
  task automatic t_regs();
    logic [7:0] v;
    for (int r = 0; r < 8; r++) begin
      v = {1'b0, 3'(r), 1'(r), 3'(7 - r)};
      wr8(8'h84, v);
      rd8(8'h84, wdata);
      `CHK("param rw", v, wdata)
    end
    for (int a = 8'h85; a <= 8'h88; a++) begin
      wr8(8'(a), 8'hff);
      rd8(8'(a), wdata);
      `CHK("ro write", 8'h00, wdata)
    end
    $display("test regs done");
  endtask
  task automatic t_meas();
    @(negedge clk) begin pv = 1'b1; pdata = 16'h1234; end
    @(negedge clk) pv = 1'b0;
    rd16(8'h87, r16);
    `CHK("prox", 16'h1234, r16)
    wr8(8'h84, 8'h02);
    c = cnt;
    go(16'd10);
    `CHK("no offset", 1'b0, coff)
    `CHK("conv req", 1'b1, req)
    wait_rdy();
    `CHK("conv count", 4, cnt - c)
    rd16(8'h85, r16);
    `CHK("avg", 16'h0019, r16)
    slow = 1'b1;
    wr8(8'h84, 8'h08);
    go(16'd100);
    `CHK("offset phase", 1'b1, coff)
    `CHK("busy", 1'b1, busy)
    wait_rdy();
    `CHK("done idle", 1'b0, busy)
    rd16(8'h85, r16);
    `CHK("offset", 16'h005f, r16)
    slow = 1'b0;
    $display("test measure done");
  endtask
  task automatic t_cont();
    c = nrdy;
    wr8(8'h84, 8'h80);
    repeat (60) @(negedge clk);
    `CHK("cont run", 1'b1, nrdy - c >= 3)
    wr8(8'h84, 8'h00);
    wait_idle();
    c = nrdy;
    repeat (60) @(negedge clk);
    `CHK("cont off", 0, nrdy - c)
    $display("test continuous done");
  endtask
  task automatic t_self();
    st_en = 1'b1;
    wait_rdy();
    c = cnt;
    wr8(8'h84, 8'h07);
    wait_rdy();
    `CHK("frozen", 1, cnt - c)
    st_en = 1'b0;
    wait_idle();
    c = cnt;
    st_en = 1'b1;
    wait_rdy();
    `CHK("applied", 128, cnt - c)
    st_en = 1'b0;
    $display("test self-timed done");
  endtask
  task automatic t_rate();
    int n;
    wr8(8'h84, 8'h10);
    wait_idle();
    st_en = 1'b1;
    wait_rdy();
    // rate code 1 halves the base period of 64 cycles
    for (n = 1; n < 200 && rdy !== 1'b1; n++) @(negedge clk);
    `CHK("rate period", 32, n)
    st_en = 1'b0;
    $display("test rate done");
  endtask

  //////////////////////////////////////////////////////////////////////////
  initial begin
    {nrst, wr, rd, st_en, od, pv, slow, load} = 8'h00;
    {addr, wdata} = 16'h0000;
    {pdata, base} = 32'h0000_0000;
    offv = 16'h0005;
    step = 16'h000a;
    num_errors = 0;
    total_checks = 0;
    nrdy = 0;
    repeat (16) @(negedge clk);
    nrst = 1'b1;
    repeat (3) @(negedge clk);
    t_reset();
    t_regs();
    t_meas();
    t_cont();
    t_self();
    t_rate();
    finish_test();
  end
  initial begin
    #400000;
    num_errors++;
    finish_test();
  end
endmodule
